// *** rtl/pump_remote_led.sv ***
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "pump_defines.svh"

module pump_remote_led
    import pump_pkg::*;
#(
    parameter int unsigned DEB_CYC = `DEB_TIME_US * (`CLK_HZ / 1000000),
    parameter int unsigned START_HOLD_CYC = `START_HOLD_MS * (`CLK_HZ / 1000),
    parameter int unsigned RESET_HOLD_CYC = `RESET_HOLD_MS * (`CLK_HZ / 1000),
    parameter int unsigned SLOT_CYC = `FLASH_SLOT_MS * (`CLK_HZ / 1000),
    parameter int unsigned NUM_CONTACTS = 6
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // parallel_remote_connector contacts
    input wire contact_pins_s pins,
    // pump state from the drive
    input wire logic power_good,
    input wire logic [15:0] rotor_rpm,
    input wire logic rotor_accel,
    input wire logic warn_active,
    input wire logic [3:0] warn_code,
    input wire logic fail_event,
    input wire logic [3:0] fail_code,
    input wire logic fail_cause,
    // commands to the drive
    output logic bearing_en,
    output logic rotate_cmd,
    // indicators
    output leds_s leds
);

    contacts_s cts;
    logic [NUM_CONTACTS-1:0] pin_vec, closed_vec;

    assign pin_vec = pins;
    assign cts = closed_vec;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CONTACTS; gi++) begin : g_filt
            contact_filter #(.DEB_CYC(DEB_CYC)) u_filt (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .pin_n(pin_vec[gi]),
                .closed(closed_vec[gi])
            );
        end
    endgenerate

    // control state
    logic src_serial_q, src_serial_d;
    logic method2_q, method2_d;
    logic run_q, run_d;
    logic rotate_q, rotate_d;
    logic bearing_q, bearing_d;
    logic fail_q, fail_d;
    logic [3:0] fcode_q, fcode_d;
    logic [31:0] start_cnt_q, start_cnt_d;
    logic [31:0] rst_cnt_q, rst_cnt_d;
    logic start_prev_q, start_prev_d;
    logic [31:0] rdata_q, rdata_d;

    logic par_active, inhibit_active, rotor_stopped;
    logic start_evt, stop_evt, reset_evt, ser_start, ser_stop, ctrl_wr;

    always_comb begin
        rotor_stopped = (rotor_rpm == 16'h0);
        par_active = cts.port_sel | ~src_serial_q;
        inhibit_active = cts.inh_en & ~cts.inhibit;
        ctrl_wr = reg_wr && (reg_addr == `REG_CTRL);
        ser_start = ctrl_wr && reg_wdata[`CTRL_SER_START] && !par_active;
        ser_stop = ctrl_wr && reg_wdata[`CTRL_SER_STOP] && !par_active;

        src_serial_d = src_serial_q;
        method2_d = method2_q;
        if (ctrl_wr) begin
            src_serial_d = reg_wdata[`CTRL_SRC_SERIAL];
            method2_d = reg_wdata[`CTRL_METHOD2];
        end

        // first method: start held beside a closed stop contact
        start_cnt_d = 32'h0;
        if (par_active && !method2_q && cts.stop && cts.start) begin
            start_cnt_d = (start_cnt_q >= 32'(START_HOLD_CYC)) ? start_cnt_q
                                                                : start_cnt_q + 32'h1;
        end
        start_prev_d = cts.start;
        start_evt = 1'b0;
        stop_evt = 1'b0;
        if (par_active) begin
            if (!method2_q) begin
                start_evt = (start_cnt_q == 32'(START_HOLD_CYC - 1)) && cts.stop
                            && cts.start;
                stop_evt = !cts.stop;
            end else begin
                start_evt = cts.start && !start_prev_q;
                stop_evt = !cts.start;
            end
        end

        // reset contact held long enough
        rst_cnt_d = 32'h0;
        if (par_active && cts.reset) begin
            rst_cnt_d = (rst_cnt_q >= 32'(RESET_HOLD_CYC)) ? rst_cnt_q
                                                            : rst_cnt_q + 32'h1;
        end
        reset_evt = (rst_cnt_q == 32'(RESET_HOLD_CYC - 1)) && cts.reset && par_active;

        // latched failure, a new event wins over the reset
        fail_d = fail_q;
        fcode_d = fcode_q;
        if (reset_evt && rotor_stopped && !fail_cause) begin
            fail_d = 1'b0;
        end
        if (fail_event) begin
            fail_d = 1'b1;
            fcode_d = fail_code;
        end

        // stored run command
        run_d = run_q;
        if (start_evt || ser_start) begin
            run_d = 1'b1;
        end
        if (stop_evt || ser_stop) begin
            run_d = 1'b0;
        end
        if (inhibit_active && rotate_q) begin
            run_d = 1'b0;
        end
        if (fail_q || fail_event) begin
            run_d = 1'b0;
        end
        rotate_d = run_d && !inhibit_active && !fail_d;

        // bearing stays up until power is gone and the rotor is still
        bearing_d = power_good || !rotor_stopped;

        rdata_d = 32'h0;
        if (reg_rd) begin
            unique case (reg_addr)
                `REG_CTRL: begin
                    rdata_d[`CTRL_SRC_SERIAL] = src_serial_q;
                    rdata_d[`CTRL_METHOD2] = method2_q;
                end
                `REG_STATUS: begin
                    rdata_d[`ST_RUN] = run_q;
                    rdata_d[`ST_PAR_ACTIVE] = par_active;
                    rdata_d[`ST_FAILURE] = fail_q;
                    rdata_d[`ST_WARNING] = warn_active;
                    rdata_d[`ST_INHIBIT] = inhibit_active;
                    rdata_d[`ST_ROTATE] = rotate_q;
                    rdata_d[`ST_CONTACT_LSB +: NUM_CONTACTS] = closed_vec;
                    rdata_d[`ST_FCODE_LSB +: 4] = fcode_q;
                end
                `REG_SPEED: begin
                    rdata_d[15:0] = rotor_rpm;
                end
                default: begin
                    rdata_d = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_serial_q <= 1'b0;
            method2_q <= 1'b0;
            run_q <= 1'b0;
            rotate_q <= 1'b0;
            bearing_q <= 1'b0;
            fail_q <= 1'b0;
            fcode_q <= 4'h0;
            start_cnt_q <= 32'h0;
            rst_cnt_q <= 32'h0;
            start_prev_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            src_serial_q <= src_serial_d;
            method2_q <= method2_d;
            run_q <= run_d;
            rotate_q <= rotate_d;
            bearing_q <= bearing_d;
            fail_q <= fail_d;
            fcode_q <= fcode_d;
            start_cnt_q <= start_cnt_d;
            rst_cnt_q <= rst_cnt_d;
            start_prev_q <= start_prev_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign bearing_en = bearing_q;
    assign rotate_cmd = rotate_q;

    // flash timing: 32 slots per frame, flash n lit in even slots below 2n
    logic [31:0] tick_q, tick_d;
    logic [4:0] slot_q, slot_d;
    leds_s leds_q, leds_d;
    band_e band;
    logic rot_on, fault_on;

    function automatic logic flash_n(input logic [3:0] n, input logic [4:0] slot);
        flash_n = !slot[0] && (slot[4:1] < n);
    endfunction

    always_comb begin
        tick_d = tick_q + 32'h1;
        slot_d = slot_q;
        if (tick_q >= 32'(SLOT_CYC - 1)) begin
            tick_d = 32'h0;
            slot_d = slot_q + 5'h1;
        end

        if (rotor_stopped) begin
            band = BAND_STOP;
        end else if (rotor_rpm <= `RPM_ONE_FLASH) begin
            band = BAND_ONE;
        end else if (rotor_rpm <= `RPM_TWO_FLASH) begin
            band = BAND_TWO;
        end else if (rotor_rpm <= `RPM_THREE_FLASH) begin
            band = BAND_THREE;
        end else if (rotor_rpm <= `RPM_CONT_FLASH) begin
            band = BAND_CONT;
        end else begin
            band = BAND_STEADY;
        end

        unique case (band)
            BAND_STOP: rot_on = 1'b0;
            BAND_ONE: rot_on = flash_n(`FLASH_N1, slot_q);
            BAND_TWO: rot_on = flash_n(`FLASH_N2, slot_q);
            BAND_THREE: rot_on = flash_n(`FLASH_N3, slot_q);
            BAND_CONT: rot_on = !slot_q[0];
            BAND_STEADY: rot_on = 1'b1;
            default: rot_on = 1'b0;
        endcase

        leds_d.power_green = bearing_q && power_good;
        leds_d.rot_green = rot_on && rotor_accel;
        leds_d.rot_orange = rot_on && !rotor_accel;
        leds_d.fault_orange = 1'b0;
        leds_d.fault_red = 1'b0;
        if (fail_q) begin
            // code zero is steady red
            fault_on = (fcode_q == 4'h0) ? 1'b1 : flash_n(fcode_q, slot_q);
            leds_d.fault_red = fault_on;
        end else if (warn_active) begin
            fault_on = (warn_code == 4'h0) ? !slot_q[0] : flash_n(warn_code, slot_q);
            leds_d.fault_orange = fault_on;
        end else begin
            fault_on = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_q <= 32'h0;
            slot_q <= 5'h0;
            leds_q <= '0;
        end else begin
            tick_q <= tick_d;
            slot_q <= slot_d;
            leds_q <= leds_d;
        end
    end

    assign leds = leds_q;

endmodule

// *** common/pump_defines.svh ***
`ifndef PUMP_DEFINES_SVH
`define PUMP_DEFINES_SVH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_SPEED 8'h08

// control register fields
`define CTRL_SRC_SERIAL 0
`define CTRL_METHOD2 1
`define CTRL_SER_START 2
`define CTRL_SER_STOP 3
`define CTRL_RESET 2'h0

// status register fields
`define ST_RUN 0
`define ST_PAR_ACTIVE 1
`define ST_FAILURE 2
`define ST_WARNING 3
`define ST_INHIBIT 4
`define ST_ROTATE 5
`define ST_CONTACT_LSB 8
`define ST_FCODE_LSB 16

// clock and times
`define CLK_HZ 50000000
`define DEB_TIME_US 1000
`define START_HOLD_MS 300
`define RESET_HOLD_MS 300
`define FLASH_SLOT_MS 100

// rotor speed band limits in rpm
`define RPM_ONE_FLASH 16'd2000
`define RPM_TWO_FLASH 16'd20000
`define RPM_THREE_FLASH 16'd40000
`define RPM_CONT_FLASH 16'd49500

// flash counts per band
`define FLASH_N1 4'h1
`define FLASH_N2 4'h2
`define FLASH_N3 4'h3

`endif

// *** common/pump_pkg.sv ***
package pump_pkg;

    // contact pins, low while the contact is closed to contact_common
    typedef struct packed {
        logic port_sel_n;
        logic inh_en_n;
        logic inhibit_n;
        logic reset_n;
        logic stop_n;
        logic start_n;
    } contact_pins_s;

    // filtered contact levels, high while closed
    typedef struct packed {
        logic port_sel;
        logic inh_en;
        logic inhibit;
        logic reset;
        logic stop;
        logic start;
    } contacts_s;

    typedef struct packed {
        logic power_green;
        logic rot_green;
        logic rot_orange;
        logic fault_orange;
        logic fault_red;
    } leds_s;

    typedef enum logic [2:0] {
        BAND_STOP = 3'b000,
        BAND_ONE = 3'b001,
        BAND_TWO = 3'b010,
        BAND_THREE = 3'b011,
        BAND_CONT = 3'b100,
        BAND_STEADY = 3'b101
    } band_e;

endpackage

// *** rtl/contact_filter.sv ***
`timescale 1ns/100ps
`include "pump_defines.svh"

module contact_filter #(
    parameter int unsigned DEB_CYC = `DEB_TIME_US * (`CLK_HZ / 1000000)
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // contact pin, low when closed
    input wire logic pin_n,
    // filtered level
    output logic closed
);

    logic s1_q, s2_q, s3_q;
    logic closed_q, closed_d;
    logic [31:0] cnt_q, cnt_d;

    always_comb begin
        closed_d = closed_q;
        cnt_d = 32'h0;
        // count while the last two stages agree on a new level
        if ((s2_q == s3_q) && (~s3_q != closed_q)) begin
            if (cnt_q >= 32'(DEB_CYC - 1)) begin
                closed_d = ~s3_q;
            end else begin
                cnt_d = cnt_q + 32'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            closed_q <= 1'b0;
            cnt_q <= 32'h0;
        end else begin
            s1_q <= pin_n;
            s2_q <= s1_q;
            s3_q <= s2_q;
            closed_q <= closed_d;
            cnt_q <= cnt_d;
        end
    end

    assign closed = closed_q;

endmodule

// *** verif/pump_remote_led_props.sv ***
`timescale 1ns/100ps
module pump_remote_led_props
    import pump_pkg::*;
#(
    parameter int unsigned DEB_CYC = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // inputs
    input wire contact_pins_s pins,
    input wire logic power_good,
    input wire logic [15:0] rotor_rpm,
    input wire logic rotor_accel,
    input wire logic warn_active,
    input wire logic fail_event,
    input wire logic [3:0] fail_code,
    // outputs
    input wire logic bearing_en,
    input wire logic rotate_cmd,
    input wire leds_s leds
);
    logic [7:0] inh_q;
    logic [7:0] inh_d;
    logic [7:0] idle_q;
    logic [7:0] idle_d;
    // cycles with inhibit effective, and with port select closed and the start and stop contacts open
    always_comb begin
        inh_d = (!pins.inh_en_n && pins.inhibit_n) ? inh_q + {7'h00, ~&inh_q} : 8'h00;
        idle_d = (!pins.port_sel_n && pins.start_n && pins.stop_n) ?
            idle_q + {7'h00, ~&idle_q} : 8'h00;
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            inh_q <= 8'h00;
            idle_q <= 8'h00;
        end else begin
            inh_q <= inh_d;
            idle_q <= idle_d;
        end
    end
    AST_PWR_LED: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 leds.power_green == $past(bearing_en && power_good))
        else $error("power led wrong");
    AST_BRG_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !power_good && rotor_rpm == 16'h0 |=> !bearing_en)
        else $error("bearing left on");
    AST_ROT_STOP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rotor_rpm == 16'h0) [*2] |=> !leds.rot_green && !leds.rot_orange)
        else $error("rotation led lit at rest");
    AST_ROT_COLOUR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rotor_accel) [*2] |=> !leds.rot_orange)
        else $error("orange while accelerating");
    AST_STEADY: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rotor_rpm > 16'd49500 && rotor_rpm <= 16'd55000 && rotor_accel) [*2]
        |=> leds.rot_green)
        else $error("steady band not lit");
    AST_FAIL_RED: assert property (@(posedge ref_clk) disable iff (!rst_n)
        fail_event && fail_code == 4'h0 |-> ##[1:3] leds.fault_red)
        else $error("failure not red");
    AST_WARN_SRC: assert property (@(posedge ref_clk) disable iff (!rst_n)
        leds.fault_orange |-> $past(warn_active) || $past(warn_active, 2))
        else $error("orange without warning");
    AST_INHIBIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        inh_q > DEB_CYC + 8 |-> !rotate_cmd)
        else $error("rotation while inhibited");
    AST_IDLE_STOP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        idle_q > DEB_CYC + 8 |-> !rotate_cmd)
        else $error("rotation with contacts open");
endmodule

bind pump_remote_led pump_remote_led_props #(.DEB_CYC(DEB_CYC)) u_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .pins(pins), .power_good(power_good),
    .rotor_rpm(rotor_rpm), .rotor_accel(rotor_accel), .warn_active(warn_active),
    .fail_event(fail_event), .fail_code(fail_code), .bearing_en(bearing_en),
    .rotate_cmd(rotate_cmd), .leds(leds));

// *** verif/contact_relay.sv ***
`timescale 1ns/100ps
module contact_relay
    import pump_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // contact pins, pulled high while open
    output contact_pins_s pins
);
    contacts_s closed_q = '0;
    assign pins = contact_pins_s'(~closed_q);
    task automatic set(input int idx, input logic cl);
        @(posedge ref_clk);
        closed_q[idx] <= cl;
    endtask
    // closure held for a set count of cycles
    task automatic pulse(input int idx, input int cyc);
        set(idx, 1'b1);
        repeat (cyc) @(posedge ref_clk);
        closed_q[idx] <= 1'b0;
        // open long enough for the filter to accept it
        repeat (12) @(posedge ref_clk);
    endtask
endmodule

// *** verif/pump_remote_led_tb_top.sv ***
`timescale 1ns/100ps
module pump_remote_led_tb_top
    import pump_pkg::*;
;
    localparam int SLOT = 4;
    localparam int FRAME = 32 * SLOT;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [31:0] rd_val;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic power_good = 1'b1;
    logic rotor_accel = 1'b1;
    logic warn_active = 1'b0;
    logic fail_event = 1'b0;
    logic fail_cause = 1'b0;
    logic [15:0] rotor_rpm = 16'h0;
    logic [3:0] warn_code = 4'h0;
    logic [3:0] fail_code = 4'h0;
    logic bearing_en;
    logic rotate_cmd;
    contact_pins_s pins;
    leds_s leds;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    int cnt[5];
    int e[$] = '{0, 2000, 20000, 40000, 49500, 55000};
    int r;
    always #10 ref_clk = ~ref_clk;

    pump_remote_led #(.DEB_CYC(4), .START_HOLD_CYC(20), .RESET_HOLD_CYC(20),
        .SLOT_CYC(SLOT)) u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins),
        .power_good(power_good), .rotor_rpm(rotor_rpm), .rotor_accel(rotor_accel),
        .warn_active(warn_active), .warn_code(warn_code), .fail_event(fail_event),
        .fail_code(fail_code), .fail_cause(fail_cause), .bearing_en(bearing_en),
        .rotate_cmd(rotate_cmd), .leds(leds));
    contact_relay u_relay (.ref_clk(ref_clk), .pins(pins));

    task automatic finish_test;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        rd_val = reg_rdata;
        @(posedge ref_clk);
    endtask
    // polls the rotate command under a bounded count, then compares
    task automatic rot(input logic v, input int n);
        repeat (n) begin
            @(negedge ref_clk);
            if (rotate_cmd === v) break;
        end
        check(rotate_cmd, v);
        @(posedge ref_clk);
    endtask
    // the rotate command must still show v after n cycles
    task automatic stay(input logic v, input int n);
        repeat (n) @(negedge ref_clk);
        check(rotate_cmd, v);
        @(posedge ref_clk);
    endtask
    // lit cycles of every indicator over one flash frame
    task automatic frame;
        cnt = '{default: 0};
        repeat (4) @(posedge ref_clk);
        repeat (FRAME) begin
            @(negedge ref_clk);
            foreach (cnt[b]) cnt[b] += int'(leds[b] === 1'b1);
        end
        @(posedge ref_clk);
    endtask
    function automatic int exp_slots(input int rpm);
        int n[$] = '{0, 1, 2, 3, 16};
        foreach (n[i]) if (rpm <= e[i]) return n[i] * SLOT;
        return FRAME;
    endfunction

    initial begin
        void'($urandom(97));
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        rotor_rpm <= 16'h1234;
        rd(8'h00);
        check(rd_val, 32'h0);
        rd(8'h08);
        check(rd_val, 32'h1234);
        rd(8'h0c);
        check(rd_val, 32'h0);
        for (int i = 0; i < 11; i++) begin
            r = (i == 0) ? 0 : (i % 2) ? e[i / 2] + 1 + $urandom_range(e[i / 2 + 1] -
                e[i / 2] - 1) : e[i / 2];
            rotor_rpm <= 16'(r);
            rotor_accel <= (i > 8) ? (i == 9) : 1'($urandom);
            frame();
            check(cnt[3], rotor_accel ? exp_slots(r) : 0);
            check(cnt[2], rotor_accel ? 0 : exp_slots(r));
            check(cnt[4], FRAME);
        end
        rotor_rpm <= 16'h0;
        fail_cause <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            r = k ? $urandom_range(15, 1) : 0;
            fail_code <= 4'(r);
            fail_event <= 1'b1;
            @(posedge ref_clk);
            fail_event <= 1'b0;
            frame();
            check(cnt[0], r ? r * SLOT : FRAME);
            check(cnt[1], 0);
        end
        u_relay.pulse(2, 40);
        rd(8'h04);
        check(rd_val[2], 1'b1);
        fail_cause <= 1'b0;
        rotor_rpm <= 16'd100;
        u_relay.pulse(2, 40);
        rd(8'h04);
        check(rd_val[2], 1'b1);
        rotor_rpm <= 16'h0;
        u_relay.pulse(2, 40);
        rd(8'h04);
        check(rd_val[2], 1'b0);
        r = $urandom_range(7, 1);
        warn_code <= 4'(r);
        warn_active <= 1'b1;
        frame();
        check(cnt[1], r * SLOT);
        check(cnt[0], 0);
        warn_active <= 1'b0;
        u_relay.set(1, 1'b1);
        u_relay.pulse(0, 10);
        stay(1'b0, 30);
        u_relay.pulse(0, 40);
        rot(1'b1, 20);
        u_relay.set(1, 1'b0);
        rot(1'b0, 20);
        wr(8'h00, 32'h2);
        u_relay.set(0, 1'b1);
        rot(1'b1, 30);
        u_relay.set(0, 1'b0);
        rot(1'b0, 20);
        u_relay.set(4, 1'b1);
        u_relay.set(0, 1'b1);
        stay(1'b0, 40);
        u_relay.set(4, 1'b0);
        rot(1'b1, 30);
        u_relay.set(4, 1'b1);
        rot(1'b0, 30);
        u_relay.set(3, 1'b1);
        stay(1'b0, 30);
        u_relay.set(0, 1'b0);
        repeat (12) @(posedge ref_clk);
        u_relay.set(0, 1'b1);
        rot(1'b1, 30);
        u_relay.set(0, 1'b0);
        rot(1'b0, 20);
        wr(8'h00, 32'h1);
        u_relay.set(1, 1'b1);
        u_relay.pulse(0, 40);
        stay(1'b0, 20);
        wr(8'h00, 32'h5);
        rot(1'b1, 20);
        wr(8'h00, 32'h9);
        rot(1'b0, 20);
        wr(8'h00, 32'h5);
        rot(1'b1, 20);
        u_relay.set(3, 1'b0);
        rot(1'b0, 30);
        u_relay.set(3, 1'b1);
        u_relay.set(5, 1'b1);
        u_relay.pulse(0, 40);
        rot(1'b1, 20);
        u_relay.set(1, 1'b0);
        rot(1'b0, 20);
        power_good <= 1'b0;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        check(bearing_en, 1'b0);
        check(leds.power_green, 1'b0);
        finish_test();
    end
endmodule
